// ==== dv/test_tplk_top.sv ====
// self-checking bench for the twisted-pair link, squelch and polarity block
`timescale 1ns/10ps
module test_tplk_top;
   localparam int TK = 20;
   logic ref_clk, rst_n, op_rx_data, op_rx_active, op_light_ok, pol_in;
   wire logic tp_rx_pos, tp_rx_neg, tp_rx_pos_low_thr, tp_rx_neg_low_thr;
   logic pol_out, pol_oe, led, tp_tx_pos, tp_tx_neg, link_fail, pr_led, pr_tx_pos;
   logic prev_neg, prev_op, data_chk, block_chk, prop_chk, pr_tx_neg, pr_fail;
   int miscompares = 0;
   int n_tests = 0;
   int n;
   int gaps [13] = '{16, 16, 16, 110, 16, 16, 16, 1, 16, 16, 16, 16, 16};

   tplk_remote_tp far_end (.ref_clk(ref_clk), .tp_rx_pos(tp_rx_pos), .tp_rx_neg(tp_rx_neg),
      .tp_rx_pos_low_thr(tp_rx_pos_low_thr), .tp_rx_neg_low_thr(tp_rx_neg_low_thr));

   tplk_top #(.TICK_CYCLES(TK), .PROPAGATE_DISCONNECT(1'b0)) DUT (.ref_clk(ref_clk),
      .rst_n(rst_n), .tp_rx_pos(tp_rx_pos), .tp_rx_neg(tp_rx_neg),
      .tp_rx_pos_low_thr(tp_rx_pos_low_thr), .tp_rx_neg_low_thr(tp_rx_neg_low_thr),
      .op_rx_data(op_rx_data), .op_rx_active(op_rx_active), .op_light_ok(op_light_ok),
      .polarity_status_or_disable_in(pol_in), .polarity_status_or_disable_out(pol_out),
      .polarity_status_or_disable_oe(pol_oe), .led_current_sink(led),
      .tp_tx_pos(tp_tx_pos), .tp_tx_neg(tp_tx_neg), .link_fail(link_fail));

   tplk_top #(.TICK_CYCLES(TK), .PROPAGATE_DISCONNECT(1'b1)) DUT_PROP (.ref_clk(ref_clk),
      .rst_n(rst_n), .tp_rx_pos(tp_rx_pos), .tp_rx_neg(tp_rx_neg),
      .tp_rx_pos_low_thr(tp_rx_pos_low_thr), .tp_rx_neg_low_thr(tp_rx_neg_low_thr),
      .op_rx_data(op_rx_data), .op_rx_active(op_rx_active), .op_light_ok(op_light_ok),
      .polarity_status_or_disable_in(pol_in), .polarity_status_or_disable_out(),
      .polarity_status_or_disable_oe(), .led_current_sink(pr_led),
      .tp_tx_pos(pr_tx_pos), .tp_tx_neg(pr_tx_neg), .link_fail(pr_fail));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ***************************************************
   // compare, verdict and hang guard
   // ***************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      test_done();
   end

   // per-cycle watchers: led follows the received low half one cycle late
   always @(negedge ref_clk) begin
      if (data_chk) check(led, prev_neg);
      if (block_chk) check(tp_tx_neg, 1'b0);
      if (prop_chk) check({pr_led, pr_tx_pos, pr_tx_neg}, 3'b000);
      if (rst_n) check(pr_fail, link_fail);
      prev_neg = tp_rx_neg_low_thr;
   end

   // negedge samples until the chosen output (0 tx pulse, 1 led) reaches v
   task automatic until_val(input int sel, input logic v, output int cnt);
      cnt = 0;
      do begin
         @(negedge ref_clk);
         cnt++;
      end while ((sel ? led : tp_tx_pos) !== v && cnt < 3000);
   endtask : until_val

   task automatic idle_run;
      int c;
      until_val(1, 1'b0, c);
      until_val(1, 1'b1, c);
      until_val(1, 1'b0, c);
      check(c, tplk_pkg::IDLE_HALF_CYC);
   endtask : idle_run

   task automatic reset(input logic strap);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      pol_in <= strap;
      op_rx_active <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check({led, tp_tx_pos, tp_tx_neg, link_fail, pol_out, pol_oe}, 6'b000110);
      rst_n <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check(pol_oe, strap);
   endtask : reset

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      {rst_n, op_rx_data, op_rx_active, op_light_ok, pol_in} = 5'h01;
      {prev_neg, prev_op, data_chk, block_chk, prop_chk} = 5'h00;
      n = $urandom(32'h6785);
      reset(1'b1);
      block_chk = 1;
      prop_chk = 1;
      until_val(0, 1'b1, n);
      until_val(0, 1'b0, n);
      check(n, tplk_pkg::LP_WIDTH_CYC);
      until_val(0, 1'b1, n);
      check((n + 2 >= 15 * TK) && (n + 2 <= 17 * TK + 4), 1'b1);
      idle_run();
      check(link_fail, 1'b1);
      prop_chk = 0;
      @(posedge ref_clk);
      op_light_ok <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         repeat (gaps[i] * TK) @(posedge ref_clk);
         far_end.pulse(1'b0);
         repeat (8) @(negedge ref_clk);
         if (i == 6) check(link_fail, 1'b1);
         if (i == 11) check(link_fail, 1'b1);
      end
      check(link_fail, 1'b0);
      block_chk = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         op_rx_active <= 1'b1;
         op_rx_data <= 1'($urandom);
         @(negedge ref_clk);
         if (i > 1) check({tp_tx_pos, tp_tx_neg}, {prev_op, ~prev_op});
         prev_op = op_rx_data;
      end
      @(posedge ref_clk);
      op_rx_active <= 1'b0;
      op_rx_data <= 1'b0;
      repeat (2) @(negedge ref_clk);
      repeat (15 * TK) begin
         @(negedge ref_clk);
         check(tp_tx_pos, 1'b0);
      end
      fork
         far_end.frame(30, 1'b0);
         begin
            repeat (13) @(posedge ref_clk);
            data_chk = 1;
            repeat (48) @(posedge ref_clk);
            data_chk = 0;
         end
      join
      idle_run();
      fork
         far_end.noise(60);
         idle_run();
      join
      for (int i = 0; i < 4; i++) begin
         check(pol_out, 1'b1);
         far_end.frame(20, 1'b1);
         repeat (10) @(negedge ref_clk);
      end
      check(pol_out, 1'b0);
      for (int i = 1; i <= 10; i++) begin
         repeat (16 * TK - 3) @(posedge ref_clk);
         far_end.pulse(1'b0);
         @(negedge ref_clk);
         if (i == 3) check(link_fail, 1'b0);
      end
      check(link_fail, 1'b1);
      reset(1'b1);
      for (int i = 0; i < 5; i++) begin
         check({pol_out, link_fail}, 2'b11);
         repeat (16 * TK) @(posedge ref_clk);
         far_end.pulse(1'b1);
         repeat (8) @(negedge ref_clk);
      end
      check({pol_out, link_fail}, 2'b00);
      reset(1'b0);
      @(posedge ref_clk);
      op_rx_active <= 1'b1;
      block_chk = 1;
      for (int i = 0; i < 4; i++) far_end.frame(20, 1'b1);
      repeat (10) @(negedge ref_clk);
      check({pol_oe, link_fail}, 2'b01);
      block_chk = 0;
      @(posedge ref_clk);
      op_rx_active <= 1'b0;
      repeat (10) @(negedge ref_clk);
      check(link_fail, 1'b0);
      test_done();
   end
endmodule : test_tplk_top

// ==== dv/tplk_remote_tp.sv ====
// behavioural far-end twisted-pair transceiver driving the receive comparators
`timescale 1ns/10ps
module tplk_remote_tp (
   input wire logic ref_clk,
   output logic tp_rx_pos,
   output logic tp_rx_neg,
   output logic tp_rx_pos_low_thr,
   output logic tp_rx_neg_low_thr
);
   // ***************************************************
   // line levels: ha strong positive, h5 strong negative
   // ***************************************************
   initial begin
      {tp_rx_pos, tp_rx_neg, tp_rx_pos_low_thr, tp_rx_neg_low_thr} = 4'h0;
   end

   // one line state per clock, changed just after the rising edge
   task automatic put(input logic [3:0] v);
      @(posedge ref_clk);
      {tp_rx_pos, tp_rx_neg, tp_rx_pos_low_thr, tp_rx_neg_low_thr} <= v;
   endtask : put

   // single two-cycle link pulse, inverted when rev is set
   task automatic pulse(input bit rev);
      repeat (2) put(rev ? 4'h5 : 4'ha);
      put(4'h0);
   endtask : pulse

   // strong preamble, body on the low comparators only, then start-of-idle hold
   task automatic frame(input int nbits, input bit end_neg);
      bit b;
      put(4'ha);
      put(4'h5);
      for (int i = 0; i < nbits; i++) begin
         b = 1'($urandom);
         put(b ? 4'h1 : 4'h2);
         put(b ? 4'h2 : 4'h1);
      end
      repeat (5) put(end_neg ? 4'h5 : 4'ha);
      put(4'h0);
   endtask : frame

   // chatter that never reaches the squelch level
   task automatic noise(input int n);
      for (int i = 0; i < n; i++) put(i[0] ? 4'h1 : 4'h2);
      put(4'h0);
   endtask : noise
endmodule : tplk_remote_tp

// ==== rtl/tplk_pkg.sv ====
// constants and types for the twisted-pair link, squelch and polarity block
package tplk_pkg;

   // ***************************************************
   // clock and derived cycle counts
   // ***************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int SOI_HOLD_NS = 160;
   localparam int SOI_CYC = (SOI_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_FREQ_KHZ = 1000;
   localparam int IDLE_HALF_NS = 1000000 / (2 * IDLE_FREQ_KHZ);
   localparam int IDLE_HALF_CYC = IDLE_HALF_NS / CLK_PERIOD_NS;
   localparam int LP_WIDTH_NS = 100;
   localparam int LP_WIDTH_CYC = LP_WIDTH_NS / CLK_PERIOD_NS;
   localparam int QUAL_WIN_NS = 300;
   localparam int QUAL_WIN_CYC = QUAL_WIN_NS / CLK_PERIOD_NS;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

   // ***************************************************
   // link timers in milliseconds
   // ***************************************************
   localparam logic [7:0] LP_PERIOD_MS = 8'h10;
   localparam logic [7:0] LINK_LOSS_MS = 8'h64;
   localparam logic [7:0] LT_MIN_MS = 8'h04;
   localparam logic [7:0] LT_MAX_MS = 8'h64;
   localparam logic [7:0] MS_SAT = 8'hff;

   // ***************************************************
   // counts
   // ***************************************************
   localparam logic [2:0] LP_GOOD_COUNT = 3'h5;
   localparam logic [2:0] POL_FRAMES = 3'h4;

   typedef enum logic [1:0] {
      LINK_PASS = 2'b00,
      LINK_FAIL = 2'b01,
      LINK_WAIT = 2'b11
   } tplk_link_t;

   typedef enum logic {
      SQ_ON = 1'b0,
      SQ_OFF = 1'b1
   } tplk_sq_t;

endpackage : tplk_pkg

// ==== rtl/tplk_top.sv ====
// twisted-pair receive squelch, optical idle, link integrity and polarity logic
`timescale 1ns/10ps
// Function
// [RULE1] led sinks current when input negative
// [RULE2] forward data only after squelch qualifies
// [RULE3] start of idle switches led to 1MHz
// [RULE4] drop at most five bits at start
// [RULE5] below 300mV never unsquelches
// [RULE6] unsquelched uses 225mV detection threshold
// [RULE7] positive hold 160ns ends packet, resquelch
// [RULE8] link pulses every 16ms when idle
// [RULE9] silence first after packet transmission ends
// [RULE10] link pulse single positive-going pulse
// [RULE11] no activity within timeout enters link fail
// [RULE12] wrong-polarity pulses ignored, do not restart timeout
// [RULE13] exit fail on packet/five pulses, when idle
// [RULE14] consecutive pulses within maximum spacing
// [RULE15] pulse inside minimum spacing is noise, resets
// [RULE16] non-propagating variant keeps pulses and idle
// [RULE17] propagating variant stops idle, pulses follow light
// [RULE18] polarity pin high correct, low reversed
// [RULE19] grounded polarity pin disables correction
// [RULE20] frame end decides polarity
// [RULE21] change polarity after four agreeing frames
// [RULE22] five reversed pulses invert polarity, leave fail
// [RULE23] timers from one free-running millisecond tick
module tplk_top #(
   parameter int TICK_CYCLES = tplk_pkg::TICK_CYC,
   parameter bit PROPAGATE_DISCONNECT = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tp_rx_pos,
   input wire logic tp_rx_neg,
   input wire logic tp_rx_pos_low_thr,
   input wire logic tp_rx_neg_low_thr,
   input wire logic op_rx_data,
   input wire logic op_rx_active,
   input wire logic op_light_ok,
   input wire logic polarity_status_or_disable_in,
   output logic polarity_status_or_disable_out,
   output logic polarity_status_or_disable_oe,
   output logic led_current_sink,
   output logic tp_tx_pos,
   output logic tp_tx_neg,
   output logic link_fail
);

   // ***************************************************
   // state
   // ***************************************************
   logic [31:0] tick_cnt, next_tick_cnt;
   logic ms_tick;
   tplk_pkg::tplk_sq_t sq_state, next_sq_state;
   tplk_pkg::tplk_link_t link_state, next_link_state;
   logic [3:0] win_cnt, next_win_cnt;
   logic seen_pos, next_seen_pos;
   logic seen_neg, next_seen_neg;
   logic [2:0] hold_pos, next_hold_pos;
   logic [2:0] hold_neg, next_hold_neg;
   logic [7:0] act_ms, next_act_ms;
   logic [7:0] gap_ms, next_gap_ms;
   logic [2:0] good_cnt, next_good_cnt;
   logic [2:0] rev_cnt, next_rev_cnt;
   logic [2:0] frm_cnt, next_frm_cnt;
   logic pol_inv, next_pol_inv;
   logic frame_seen, next_frame_seen;
   logic strap_done, next_strap_done;
   logic pol_disable, next_pol_disable;
   logic [3:0] idle_cnt, next_idle_cnt;
   logic idle_lvl, next_idle_lvl;
   logic [7:0] lp_ms, next_lp_ms;
   logic [1:0] lp_w, next_lp_w;
   logic next_led, next_txp, next_txn;

   // corrected comparator views
   logic pos_c, neg_c, pos_lo_c, neg_lo_c;
   logic good_lp, rev_lp, pkt_start, frame_end, ended_neg, tx_busy;

   function automatic logic [7:0] ms_inc(input logic [7:0] v, input logic tk);
      ms_inc = (tk && v != tplk_pkg::MS_SAT) ? v + 8'h01 : v;
   endfunction : ms_inc

   assign pos_c = pol_inv ? tp_rx_neg : tp_rx_pos;
   assign neg_c = pol_inv ? tp_rx_pos : tp_rx_neg;
   assign pos_lo_c = pol_inv ? tp_rx_neg_low_thr : tp_rx_pos_low_thr;
   assign neg_lo_c = pol_inv ? tp_rx_pos_low_thr : tp_rx_neg_low_thr;
   assign ms_tick = (tick_cnt == 32'(TICK_CYCLES - 1));

   // ***************************************************
   // next-state logic
   // ***************************************************
   always_comb begin
      next_tick_cnt = ms_tick ? 32'h0 : tick_cnt + 32'h1; // see [RULE23]
      next_sq_state = sq_state;
      next_win_cnt = win_cnt;
      next_seen_pos = seen_pos;
      next_seen_neg = seen_neg;
      next_hold_pos = 3'h0;
      next_hold_neg = 3'h0;
      good_lp = 1'b0;
      rev_lp = 1'b0;
      pkt_start = 1'b0;
      frame_end = 1'b0;
      ended_neg = 1'b0;
      case (sq_state)
         tplk_pkg::SQ_ON: begin
            // only full squelch-level excursions count here; see [RULE5]
            next_seen_pos = seen_pos | pos_c;
            next_seen_neg = seen_neg | neg_c;
            if (seen_pos || seen_neg || pos_c || neg_c) begin
               next_win_cnt = win_cnt + 4'h1;
            end
            if (next_seen_pos && next_seen_neg) begin
               // both swings inside a short window: a packet; see [RULE2] [RULE4]
               next_sq_state = tplk_pkg::SQ_OFF;
               pkt_start = 1'b1;
               next_win_cnt = 4'h0;
               next_seen_pos = 1'b0;
               next_seen_neg = 1'b0;
            end else if (next_win_cnt == 4'(tplk_pkg::QUAL_WIN_CYC)) begin
               good_lp = seen_pos;
               rev_lp = seen_neg;
               next_win_cnt = 4'h0;
               next_seen_pos = 1'b0;
               next_seen_neg = 1'b0;
            end
         end
         tplk_pkg::SQ_OFF: begin
            // lowered threshold while the packet runs; see [RULE6]
            if (pos_lo_c && !neg_lo_c) begin
               next_hold_pos = hold_pos + 3'h1;
            end
            if (neg_lo_c && !pos_lo_c) begin
               next_hold_neg = hold_neg + 3'h1;
            end
            if (next_hold_pos == 3'(tplk_pkg::SOI_CYC)) begin
               next_sq_state = tplk_pkg::SQ_ON; // see [RULE7]
               frame_end = 1'b1;
            end else if (next_hold_neg == 3'(tplk_pkg::SOI_CYC)) begin
               next_sq_state = tplk_pkg::SQ_ON; // see [RULE20]
               frame_end = 1'b1;
               ended_neg = 1'b1;
            end
         end
         default: begin
            next_sq_state = tplk_pkg::SQ_ON;
         end
      endcase

      // strap sampled once after reset release; see [RULE19]
      next_strap_done = 1'b1;
      next_pol_disable = strap_done ? pol_disable : ~polarity_status_or_disable_in;

      // frame polarity voting; see [RULE20] [RULE21]
      next_frame_seen = frame_seen | frame_end;
      next_frm_cnt = frm_cnt;
      next_pol_inv = pol_inv;
      if (frame_end && !pol_disable) begin
         if (ended_neg) begin
            next_frm_cnt = frm_cnt + 3'h1;
            if (next_frm_cnt == tplk_pkg::POL_FRAMES) begin
               next_pol_inv = ~pol_inv;
               next_frm_cnt = 3'h0;
            end
         end else begin
            next_frm_cnt = 3'h0;
         end
      end

      // pulse spacing; see [RULE14] [RULE15]
      next_gap_ms = ms_inc(gap_ms, ms_tick);
      next_good_cnt = good_cnt;
      next_rev_cnt = rev_cnt;
      if (good_lp || rev_lp) begin
         next_gap_ms = 8'h00;
         if (gap_ms < tplk_pkg::LT_MIN_MS) begin
            next_good_cnt = 3'h0;
            next_rev_cnt = 3'h0;
         end else if (gap_ms <= tplk_pkg::LT_MAX_MS) begin
            next_good_cnt = good_lp ? ((good_cnt == 3'h7) ? good_cnt : good_cnt + 3'h1) : 3'h0;
            next_rev_cnt = rev_lp ? ((rev_cnt == 3'h7) ? rev_cnt : rev_cnt + 3'h1) : 3'h0;
         end else begin
            next_good_cnt = good_lp ? 3'h1 : 3'h0;
            next_rev_cnt = rev_lp ? 3'h1 : 3'h0;
         end
      end

      // activity timeout ignores reversed pulses; see [RULE11] [RULE12]
      next_act_ms = (pkt_start || good_lp) ? 8'h00 : ms_inc(act_ms, ms_tick);
      next_link_state = link_state;
      case (link_state)
         tplk_pkg::LINK_PASS: begin
            if (act_ms >= tplk_pkg::LINK_LOSS_MS) begin
               next_link_state = tplk_pkg::LINK_FAIL; // see [RULE11]
            end
         end
         tplk_pkg::LINK_FAIL: begin
            if (pkt_start || next_good_cnt >= tplk_pkg::LP_GOOD_COUNT) begin
               next_link_state = tplk_pkg::LINK_WAIT; // see [RULE13]
            end else if (!frame_seen && !pol_disable &&
                         next_rev_cnt >= tplk_pkg::LP_GOOD_COUNT) begin
               next_pol_inv = ~pol_inv; // see [RULE22]
               next_rev_cnt = 3'h0;
               next_link_state = tplk_pkg::LINK_WAIT;
            end
         end
         tplk_pkg::LINK_WAIT: begin
            next_act_ms = 8'h00;
            if (!op_rx_active && sq_state == tplk_pkg::SQ_ON) begin
               next_link_state = tplk_pkg::LINK_PASS; // see [RULE13]
            end
         end
         default: begin
            next_link_state = tplk_pkg::LINK_FAIL;
         end
      endcase

      // optical side: data when qualified on a passing link, dark on a failed link when propagating, else 1MHz idle; see [RULE1] [RULE3]
      next_idle_cnt = idle_cnt + 4'h1;
      next_idle_lvl = idle_lvl;
      if (next_idle_cnt == 4'(tplk_pkg::IDLE_HALF_CYC)) begin
         next_idle_cnt = 4'h0;
         next_idle_lvl = ~idle_lvl;
      end
      if (sq_state == tplk_pkg::SQ_OFF && link_state == tplk_pkg::LINK_PASS) begin
         next_led = neg_lo_c; // see [RULE1] [RULE2]
      end else if (PROPAGATE_DISCONNECT && link_state != tplk_pkg::LINK_PASS) begin
         next_led = 1'b0; // see [RULE17]
      end else begin
         next_led = idle_lvl; // see [RULE3] [RULE16]
      end

      // twisted-pair transmit: data, or link pulses after silence
      tx_busy = op_rx_active && link_state == tplk_pkg::LINK_PASS;
      next_lp_ms = tx_busy ? 8'h00 : ms_inc(lp_ms, ms_tick); // see [RULE9]
      next_lp_w = (lp_w != 2'h0) ? lp_w - 2'h1 : 2'h0;
      if (!tx_busy && lp_ms >= tplk_pkg::LP_PERIOD_MS) begin
         next_lp_ms = 8'h00; // see [RULE8]
         if (!PROPAGATE_DISCONNECT || op_light_ok) begin
            next_lp_w = 2'(tplk_pkg::LP_WIDTH_CYC); // see [RULE16] [RULE17]
         end
      end
      if (tx_busy) begin
         next_txp = op_rx_data;
         next_txn = ~op_rx_data;
      end else begin
         next_txp = (lp_w != 2'h0); // see [RULE10]
         next_txn = 1'b0;
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 32'h0;
         sq_state <= tplk_pkg::SQ_ON;
         link_state <= tplk_pkg::LINK_FAIL;
         win_cnt <= 4'h0;
         seen_pos <= 1'b0;
         seen_neg <= 1'b0;
         hold_pos <= 3'h0;
         hold_neg <= 3'h0;
         act_ms <= 8'h00;
         gap_ms <= tplk_pkg::MS_SAT;
         good_cnt <= 3'h0;
         rev_cnt <= 3'h0;
         frm_cnt <= 3'h0;
         pol_inv <= 1'b0;
         frame_seen <= 1'b0;
         strap_done <= 1'b0;
         pol_disable <= 1'b0;
         idle_cnt <= 4'h0;
         idle_lvl <= 1'b0;
         lp_ms <= 8'h00;
         lp_w <= 2'h0;
         led_current_sink <= 1'b0;
         tp_tx_pos <= 1'b0;
         tp_tx_neg <= 1'b0;
         link_fail <= 1'b1;
         polarity_status_or_disable_out <= 1'b1;
         polarity_status_or_disable_oe <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         sq_state <= next_sq_state;
         link_state <= next_link_state;
         win_cnt <= next_win_cnt;
         seen_pos <= next_seen_pos;
         seen_neg <= next_seen_neg;
         hold_pos <= next_hold_pos;
         hold_neg <= next_hold_neg;
         act_ms <= next_act_ms;
         gap_ms <= next_gap_ms;
         good_cnt <= next_good_cnt;
         rev_cnt <= next_rev_cnt;
         frm_cnt <= next_frm_cnt;
         pol_inv <= next_pol_inv;
         frame_seen <= next_frame_seen;
         strap_done <= next_strap_done;
         pol_disable <= next_pol_disable;
         idle_cnt <= next_idle_cnt;
         idle_lvl <= next_idle_lvl;
         lp_ms <= next_lp_ms;
         lp_w <= next_lp_w;
         led_current_sink <= next_led;
         tp_tx_pos <= next_txp;
         tp_tx_neg <= next_txn;
         link_fail <= (next_link_state != tplk_pkg::LINK_PASS);
         polarity_status_or_disable_out <= ~next_pol_inv; // see [RULE18]
         polarity_status_or_disable_oe <= strap_done && !next_pol_disable; // see [RULE19]
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_pos_hold;
      (sq_state == tplk_pkg::SQ_OFF && pos_lo_c && !neg_lo_c)[*4];
   endsequence

   property p_soi_resquelch;
      s_pos_hold |=> sq_state == tplk_pkg::SQ_ON;
   endproperty
   a_soi_resquelch: assert property (p_soi_resquelch) // see [RULE7]
      else $error("start of idle did not resquelch");

   property p_quiet_stays_squelched;
      (sq_state == tplk_pkg::SQ_ON && !tp_rx_pos && !tp_rx_neg && !seen_pos && !seen_neg)
         |=> sq_state == tplk_pkg::SQ_ON;
   endproperty
   a_quiet_stays_squelched: assert property (p_quiet_stays_squelched) // see [RULE5]
      else $error("unsquelched without input");

   property p_led_data;
      (sq_state == tplk_pkg::SQ_OFF && link_state == tplk_pkg::LINK_PASS)
         |=> led_current_sink == $past(neg_lo_c);
   endproperty
   a_led_data: assert property (p_led_data) // see [RULE1]
      else $error("led does not follow negative input");

   property p_fail_after_loss;
      (link_state == tplk_pkg::LINK_PASS && act_ms >= tplk_pkg::LINK_LOSS_MS)
         |=> link_state == tplk_pkg::LINK_FAIL ##0 link_fail;
   endproperty
   a_fail_after_loss: assert property (p_fail_after_loss) // see [RULE11]
      else $error("link loss not detected");

   property p_wait_holds;
      (link_state == tplk_pkg::LINK_WAIT && op_rx_active) |=> link_state != tplk_pkg::LINK_PASS;
   endproperty
   a_wait_holds: assert property (p_wait_holds) // see [RULE13]
      else $error("link restored while transmit busy");

   property p_fail_no_tx_data;
      (link_state != tplk_pkg::LINK_PASS) |=> !tp_tx_neg;
   endproperty
   a_fail_no_tx_data: assert property (p_fail_no_tx_data) // see [RULE16]
      else $error("data sent while link failed");

   property p_pol_pin;
      polarity_status_or_disable_oe |-> polarity_status_or_disable_out == !pol_inv;
   endproperty
   a_pol_pin: assert property (p_pol_pin) // see [RULE18]
      else $error("polarity pin disagrees with state");

   property p_disabled_fixed;
      pol_disable |=> $stable(pol_inv) && !polarity_status_or_disable_oe;
   endproperty
   a_disabled_fixed: assert property (p_disabled_fixed) // see [RULE19]
      else $error("polarity changed while disabled");

   property p_pol_change_cause;
      $changed(pol_inv) |-> $past(frm_cnt) == 3'h3 || $past(rev_cnt) >= 3'h4;
   endproperty
   a_pol_change_cause: assert property (p_pol_change_cause) // see [RULE21]
      else $error("polarity flipped without enough evidence");

endmodule : tplk_top
